// File: core/pfsms_map.vh
// Register map, field positions, reset values and timing constants of the supply sequencer.
// Summary of operation
// R1: Monitor always on outside stop mode; code: off in POR, periodic in supply fail unless the interval select is 0.
// R2: Stop monitor disable resets to one.
// R3: Disabled stop monitor detects no warning, no reset.
// R4: Fail monitor continuous or every 2^11/12/13 ticks.
// R5: Sampling window powers detector two ring ticks.
// R6: Above reset level: one more tick, then release.
// R7: Fail exit restarts at 8000h after warmup.
// R8: Pin/watchdog reset keeps monitor, regulator, crystal on.
// R9: Pin/watchdog reset released within 20 cycles.
// R10: Persistent warning level sets flag, optional interrupt.
// R11: Fail level: reset CPU, power down, retain, sample.
// R12: Below power-on level: held in reset.
// R13: Stop halts CPU, keeps state and memory.
// R14: Stop exits on I/O, warning, timer, fail.
// R15: Wake timer counts 125us ring ticks, 16 bits.
// R16: Stop warning enables power, warms up, exits.
// R17: Crystal warmup is a configurable cycle count.
// R18: Comparators pass two flops before sequencing uses them.
`ifndef PFSMS_MAP_VH
`define PFSMS_MAP_VH

// Register byte offsets.
`define PFSMS_OFS_CTRL        8'h00
`define PFSMS_OFS_WAKE        8'h04
`define PFSMS_OFS_STATUS      8'h08
`define PFSMS_OFS_IRQ_STAT    8'h0c
`define PFSMS_OFS_IRQ_MASK    8'h10

// Control register fields and reset values.
`define PFSMS_CTRL_DIS_BIT    0
`define PFSMS_CTRL_SEL_LSB    1
`define PFSMS_CTRL_STOP_BIT   3
`define PFSMS_CTRL_DIS_RST    1'b1
`define PFSMS_CTRL_SEL_RST    2'h0
`define PFSMS_WAKE_RST        16'h0000
`define PFSMS_MASK_RST        4'h0

// Interrupt status bits.
`define PFSMS_IRQ_WARN        0
`define PFSMS_IRQ_WAKE        1
`define PFSMS_IRQ_FAIL        2
`define PFSMS_IRQ_STOPX       3

// Restart addresses.
`define PFSMS_UTIL_ROM_ADDR   16'h8000
`define PFSMS_NORM_ADDR       16'h0000

// Timing.
`define PFSMS_CLK_PERIOD_NS   10
`define PFSMS_XTAL_WARMUP_NS  2000000
`define PFSMS_WARN_PERSIST_NS 20000
`define PFSMS_EXT_REL_MAX     20

`endif

// File: core/pfsms_top.v
// Supply supervision, reset hold and stop-mode wake-up sequencer with an AHB-Lite register slave.
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "pfsms_map.vh"

module pfsms_top #(
    parameter XTAL_WARMUP_CYC = (`PFSMS_XTAL_WARMUP_NS + `PFSMS_CLK_PERIOD_NS - 1) / `PFSMS_CLK_PERIOD_NS
) (
    // Clock and reset.
    input  wire        clk_sys,
    input  wire        rst_b,
    // AHB-Lite slave.
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Analog comparators and ring oscillator, all asynchronous.
    input  wire        cmp_below_por,
    input  wire        cmp_below_rst,
    input  wire        cmp_below_warn,
    input  wire        ring_osc_clk,
    // Other reset and wake sources.
    input  wire        ext_reset_pin_b,
    input  wire        wdt_reset,
    input  wire        io_wake_irq,
    // Power and CPU controls.
    output reg         regulator_en,
    output reg         crystal_en,
    output reg         monitor_on,
    output reg         sram_retain,
    output reg         cpu_rst_b,
    output reg         cpu_stop,
    output reg  [15:0] boot_addr,
    output wire        supply_warning_flag,
    output wire        irq
);

    localparam WARN_PERSIST_CYC = (`PFSMS_WARN_PERSIST_NS + `PFSMS_CLK_PERIOD_NS - 1) / `PFSMS_CLK_PERIOD_NS;

    // Sequencer states.
    localparam [2:0] ST_POR    = 3'h0;
    localparam [2:0] ST_WARMUP = 3'h1;
    localparam [2:0] ST_RUN    = 3'h2;
    localparam [2:0] ST_STOP   = 3'h3;
    localparam [2:0] ST_WAKEUP = 3'h4;
    localparam [2:0] ST_PFAIL  = 3'h5;
    localparam [2:0] ST_EXTRST = 3'h6;

    // Ring ticks between sampling windows for a given interval select.
    function [12:0] period_limit;
        input [1:0] sel;
        begin
            case (sel)
                2'h1:    period_limit = 13'h07ff;
                2'h2:    period_limit = 13'h0fff;
                2'h3:    period_limit = 13'h1fff;
                default: period_limit = 13'h0000;
            endcase
        end
    endfunction

    reg  [1:0]  rst_sync_r;
    wire        rst_n;
    reg  [4:0]  sync1_r;
    reg  [4:0]  sync2_r;
    reg         ring_prev_r;
    wire        ring_tick;
    wire        below_por;
    wire        below_rst;
    wire        below_warn;
    wire        ext_rst;
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [19:0] warm_cnt_r;
    reg  [15:0] warn_cnt_r;
    reg  [12:0] per_cnt_r;
    reg  [1:0]  win_r;
    reg  [15:0] wake_cnt_r;
    reg         util_boot_r;
    reg         stop_dis_r;
    reg  [1:0]  mon_sel_r;
    reg  [15:0] wake_val_r;
    reg  [3:0]  irq_stat_r;
    reg  [3:0]  irq_mask_r;
    reg         wr_pend_r;
    reg  [7:0]  wr_addr_r;
    reg         stop_go;
    reg  [3:0]  irq_set;
    wire        acc;
    wire        warm_done;
    wire        warn_persist;
    wire        wake_expire;
    wire        sample_edge;
    wire        stop_mon;

    // Reset is asserted at once but released through two flops so that no flop sees a ragged edge.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Two-flop synchronisers for the comparators, the reset pin and the ring oscillator.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r     <= 5'h0f;
            sync2_r     <= 5'h0f;
            ring_prev_r <= 1'b0;
        end else begin
            sync1_r     <= {ring_osc_clk, ext_reset_pin_b, cmp_below_warn, cmp_below_rst, cmp_below_por}; // R18
            sync2_r     <= sync1_r; // R18
            ring_prev_r <= sync2_r[4];
        end
    end
    assign below_por  = sync2_r[0];
    assign below_rst  = sync2_r[1];
    assign below_warn = sync2_r[2];
    assign ext_rst    = ~sync2_r[3] | wdt_reset;
    assign ring_tick  = sync2_r[4] & ~ring_prev_r;

    assign warm_done    = (warm_cnt_r >= XTAL_WARMUP_CYC[19:0]); // R17
    assign warn_persist = (warn_cnt_r >= WARN_PERSIST_CYC[15:0]); // R10
    assign wake_expire  = (wake_val_r != 16'h0000) && (wake_cnt_r >= wake_val_r) && ring_tick; // R15
    assign sample_edge  = ring_tick && (win_r >= 2'h2);
    // The stop-mode detector is shut down entirely when monitoring is disabled.
    assign stop_mon     = ~stop_dis_r; // R3

    // Next-state decision; below power-on level overrides everything.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_POR: begin
                if (!below_por) begin
                    state_nxt = ST_WARMUP;
                end
            end
            ST_WARMUP, ST_WAKEUP: begin
                if (warm_done && !below_rst) begin // R7
                    state_nxt = ST_RUN;
                end else if (warm_done && state_r == ST_WAKEUP) begin
                    state_nxt = ST_PFAIL;
                end
            end
            ST_RUN: begin
                if (below_rst) begin
                    state_nxt = ST_PFAIL; // R11
                end else if (ext_rst) begin
                    state_nxt = ST_EXTRST; // R8
                end else if (stop_go) begin
                    state_nxt = ST_STOP; // R13
                end
            end
            ST_STOP: begin
                if (stop_mon && below_rst) begin
                    state_nxt = ST_PFAIL; // R14
                end else if (ext_rst) begin
                    state_nxt = ST_EXTRST;
                end else if ((stop_mon && below_warn) || io_wake_irq || wake_expire) begin
                    state_nxt = ST_WAKEUP; // R16
                end
            end
            ST_PFAIL: begin
                if (sample_edge && win_r == 2'h3 && !below_rst) begin
                    state_nxt = ST_WARMUP; // R6
                end
            end
            ST_EXTRST: begin
                if (below_rst) begin
                    state_nxt = ST_PFAIL;
                end else if (!ext_rst) begin
                    state_nxt = ST_RUN; // R9
                end
            end
            default: begin
                state_nxt = ST_POR;
            end
        endcase
        if (below_por) begin
            state_nxt = ST_POR; // R12
        end
    end

    // State register, crystal warmup counter and restart-address memory.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_POR;
            warm_cnt_r  <= 20'h00000;
            util_boot_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // Counting starts when the oscillator is first enabled by the new state.
            if (state_nxt != state_r) begin
                warm_cnt_r <= 20'h00000;
            end else if (!warm_done) begin
                warm_cnt_r <= warm_cnt_r + 20'h00001; // R17
            end
            if (state_nxt == ST_PFAIL) begin
                util_boot_r <= 1'b1; // R7
            end else if (state_nxt == ST_POR) begin
                util_boot_r <= 1'b0;
            end
        end
    end

    // Periodic monitor: interval counter, then a two-tick window, then one extra tick when above level.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_r <= 13'h0000;
            win_r     <= 2'h0;
        end else if (state_r != ST_PFAIL) begin
            per_cnt_r <= 13'h0000;
            win_r     <= 2'h0;
        end else if (ring_tick) begin
            if (win_r == 2'h0) begin
                if (per_cnt_r >= period_limit(mon_sel_r)) begin // R4
                    per_cnt_r <= 13'h0000;
                    win_r     <= 2'h1;
                end else begin
                    per_cnt_r <= per_cnt_r + 13'h0001;
                end
            end else if (win_r == 2'h1) begin
                win_r <= 2'h2; // R5
            end else if (win_r == 2'h2 && !below_rst) begin
                win_r <= 2'h3; // R6
            end else begin
                win_r <= 2'h0;
            end
        end
    end

    // Warning persistence counter and wake timer.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            warn_cnt_r <= 16'h0000;
            wake_cnt_r <= 16'h0000;
        end else begin
            if (below_warn && !below_rst && (state_r == ST_RUN || state_r == ST_EXTRST)) begin
                if (!warn_persist) begin
                    warn_cnt_r <= warn_cnt_r + 16'h0001; // R10
                end
            end else begin
                warn_cnt_r <= 16'h0000;
            end
            // Each ring tick is 125 us, so 16 bits reach about eight seconds.
            if (state_r != ST_STOP) begin
                wake_cnt_r <= 16'h0000;
            end else if (ring_tick && wake_cnt_r != 16'hffff) begin
                wake_cnt_r <= wake_cnt_r + 16'h0001; // R15
            end
        end
    end

    // Power, monitor and CPU control outputs, all from flops.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regulator_en <= 1'b0;
            crystal_en   <= 1'b0;
            monitor_on   <= 1'b1;
            sram_retain  <= 1'b0;
            cpu_rst_b    <= 1'b0;
            cpu_stop     <= 1'b0;
            boot_addr    <= `PFSMS_NORM_ADDR;
        end else begin
            regulator_en <= (state_nxt == ST_WARMUP) || (state_nxt == ST_RUN) ||
                            (state_nxt == ST_WAKEUP) || (state_nxt == ST_EXTRST); // R8
            crystal_en   <= (state_nxt == ST_WARMUP) || (state_nxt == ST_RUN) ||
                            (state_nxt == ST_WAKEUP) || (state_nxt == ST_EXTRST); // R11
            monitor_on   <= (state_nxt == ST_STOP) ? stop_mon : // R3
                            (state_nxt == ST_PFAIL) ? ((mon_sel_r == 2'h0) || (win_r != 2'h0)) : // R5
                            (state_nxt != ST_POR); // R1
            sram_retain  <= (state_nxt == ST_PFAIL) || (state_nxt == ST_STOP); // R11
            cpu_rst_b    <= (state_nxt == ST_RUN) || (state_nxt == ST_STOP) || (state_nxt == ST_WAKEUP); // R12
            cpu_stop     <= (state_nxt == ST_STOP) || (state_nxt == ST_WAKEUP); // R13
            boot_addr    <= util_boot_r ? `PFSMS_UTIL_ROM_ADDR : `PFSMS_NORM_ADDR; // R7
        end
    end

    // Interrupt events into the sticky status; the warning event stays high while the warning persists, the others are one-cycle pulses.
    always @* begin
        irq_set = 4'h0;
        irq_set[`PFSMS_IRQ_WARN]  = warn_persist ||
                                    (state_r == ST_STOP && stop_mon && below_warn && !below_rst); // R10
        irq_set[`PFSMS_IRQ_WAKE]  = (state_r == ST_STOP) && wake_expire;
        irq_set[`PFSMS_IRQ_FAIL]  = (state_nxt == ST_PFAIL) && (state_r != ST_PFAIL);
        irq_set[`PFSMS_IRQ_STOPX] = (state_r == ST_WAKEUP) && (state_nxt == ST_RUN); // R14
    end

    // AHB-Lite slave: zero wait states, always OKAY, writes land in the data phase.
    assign acc       = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always @* begin
        stop_go = wr_pend_r && (wr_addr_r == `PFSMS_OFS_CTRL) && hwdata[`PFSMS_CTRL_STOP_BIT];
    end

    // Register writes; a hardware set beats a software clear in the same cycle.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 8'h00;
            stop_dis_r <= `PFSMS_CTRL_DIS_RST; // R2
            mon_sel_r  <= `PFSMS_CTRL_SEL_RST;
            wake_val_r <= `PFSMS_WAKE_RST;
            irq_stat_r <= 4'h0;
            irq_mask_r <= `PFSMS_MASK_RST;
        end else begin
            wr_pend_r <= acc && hwrite;
            if (acc) begin
                wr_addr_r <= haddr;
            end
            if (wr_pend_r && wr_addr_r == `PFSMS_OFS_CTRL) begin
                stop_dis_r <= hwdata[`PFSMS_CTRL_DIS_BIT];
                mon_sel_r  <= hwdata[`PFSMS_CTRL_SEL_LSB+1:`PFSMS_CTRL_SEL_LSB];
            end
            if (wr_pend_r && wr_addr_r == `PFSMS_OFS_WAKE) begin
                wake_val_r <= hwdata[15:0];
            end
            if (wr_pend_r && wr_addr_r == `PFSMS_OFS_IRQ_MASK) begin
                irq_mask_r <= hwdata[3:0];
            end
            if (wr_pend_r && wr_addr_r == `PFSMS_OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~hwdata[3:0]) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
        end
    end

    // Read data is registered in the address phase so it stands through the data phase.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (acc && !hwrite) begin
            case (haddr)
                `PFSMS_OFS_CTRL:     hrdata <= {28'h0000000, 1'b0, mon_sel_r, stop_dis_r};
                `PFSMS_OFS_WAKE:     hrdata <= {16'h0000, wake_val_r};
                `PFSMS_OFS_STATUS:   hrdata <= {24'h000000, below_rst, below_warn, util_boot_r, monitor_on,
                                                ~cpu_rst_b, state_r};
                `PFSMS_OFS_IRQ_STAT: hrdata <= {28'h0000000, irq_stat_r};
                `PFSMS_OFS_IRQ_MASK: hrdata <= {28'h0000000, irq_mask_r};
                default:             hrdata <= 32'h00000000;
            endcase
        end
    end

    // One level interrupt while any unmasked status bit is set.
    assign irq                 = |(irq_stat_r & irq_mask_r); // R10
    assign supply_warning_flag = irq_stat_r[`PFSMS_IRQ_WARN];

endmodule

// File: dv/pfsms_checker.sv
// Concurrent checks on the supply sequencer ports.
`timescale 1ns/100ps
module pfsms_checker #(
    parameter XTAL_WARMUP_CYC = 20
) (
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Bus answer.
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Comparators and reset sources.
    input wire logic        cmp_below_por,
    input wire logic        cmp_below_rst,
    input wire logic        cmp_below_warn,
    input wire logic        ext_reset_pin_b,
    input wire logic        wdt_reset,
    // Power and CPU controls.
    input wire logic        regulator_en,
    input wire logic        crystal_en,
    input wire logic        monitor_on,
    input wire logic        sram_retain,
    input wire logic        cpu_rst_b,
    input wire logic        cpu_stop,
    input wire logic [15:0] boot_addr,
    input wire logic        supply_warning_flag
);
    localparam int WARN_CYC = 2000; // Warning persistence in clock cycles.
    int   xtal_cnt;
    int   warn_cnt;
    logic fail_seen_r;

    // Crystal on-time, warning dwell and supply-fail history; runs are short enough that no counter wraps.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            xtal_cnt    <= 0;
            warn_cnt    <= 0;
            fail_seen_r <= 1'b0;
        end else begin
            xtal_cnt    <= crystal_en ? xtal_cnt + 1 : 0;
            warn_cnt    <= (cmp_below_warn && !cmp_below_rst) ? warn_cnt + 1 : 0;
            fail_seen_r <= !cmp_below_por && (fail_seen_r || (sram_retain && !cpu_rst_b && !regulator_en));
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    run_monitor_a: assert property (cpu_rst_b && !cpu_stop |-> monitor_on)
        else $error("monitor off while running");
    stop_quiet_a: assert property (cpu_stop && !monitor_on && !regulator_en && !cmp_below_por |=> cpu_rst_b)
        else $error("reset taken with stop monitor off");
    fail_power_a: assert property ($rose(cmp_below_rst) && cpu_rst_b && !cpu_stop && !cmp_below_por
        |-> ##[2:5] (!cpu_rst_b && !regulator_en && !crystal_en && sram_retain))
        else $error("supply fail did not power down");
    por_hold_a: assert property (cmp_below_por [*6] |-> !cpu_rst_b)
        else $error("cpu runs below power-on level");
    warm_release_a: assert property ($rose(cpu_rst_b) || ($fell(cpu_stop) && cpu_rst_b)
        |-> xtal_cnt >= XTAL_WARMUP_CYC - 1)
        else $error("cpu released before crystal warmup");
    boot_addr_a: assert property ($rose(cpu_rst_b) |-> boot_addr == (fail_seen_r ? 16'h8000 : 16'h0000))
        else $error("wrong restart address");
    warn_persist_a: assert property ($rose(supply_warning_flag) && !cpu_stop |-> cpu_rst_b && warn_cnt >= WARN_CYC)
        else $error("warning flag too early");
    stop_enter_a: assert property ($rose(cpu_stop) |-> cpu_rst_b && sram_retain && !regulator_en && !crystal_en)
        else $error("stop entry state wrong");
    wake_power_a: assert property ($fell(cpu_stop) && cpu_rst_b |-> regulator_en && crystal_en)
        else $error("stop exit without power");
    ext_keep_a: assert property ((!ext_reset_pin_b || wdt_reset) [*5] ##0 !cmp_below_rst
        |-> !cpu_rst_b && regulator_en && crystal_en && monitor_on)
        else $error("pin reset state wrong");
    ext_release_a: assert property (($rose(ext_reset_pin_b) || $fell(wdt_reset)) && ext_reset_pin_b
        && !wdt_reset && regulator_en && !cpu_rst_b |-> ##[1:19] cpu_rst_b)
        else $error("pin reset release late");
endmodule

// File: dv/pfsms_supply_model.sv
// Behavioural supply comparators and free-running ring oscillator.
`timescale 1ns/100ps
module pfsms_supply_model #(
    parameter real RING_HALF_NS = 41.3
) (
    // Supply level: 0 good, 1 warning band, 2 below reset, 3 below power-on.
    input  wire logic [1:0] supply_lvl,
    // Comparator results and oscillator.
    output wire logic       cmp_below_por,
    output wire logic       cmp_below_rst,
    output wire logic       cmp_below_warn,
    output logic            ring_osc_clk
);
    // Thresholds nest; the small delay keeps comparator edges away from the clock edge.
    assign #3 cmp_below_por  = (supply_lvl == 2'h3);
    assign #3 cmp_below_rst  = (supply_lvl >= 2'h2);
    assign #3 cmp_below_warn = (supply_lvl != 2'h0);

    // The ring runs much faster than on silicon so that periodic sampling fits in a short run.
    initial begin
        ring_osc_clk = 1'b0;
        #7;
        forever #(RING_HALF_NS) ring_osc_clk = ~ring_osc_clk;
    end
endmodule

// File: dv/tb.sv
// Self-checking bench for the supply sequencer.
`timescale 1ns/100ps
module tb;
    localparam int XW = 20;
    logic        clk_sys, rst_b, hsel, hwrite, ext_reset_pin_b, wdt_reset, io_wake_irq, pr, pr_seen;
    logic [7:0]  haddr;
    logic [1:0]  htrans, supply_lvl;
    logic [31:0] hwdata, obs, seed;
    logic [63:0] q[$];
    logic [63:0] e;
    int          failures, samples_checked;
    wire         hreadyout, hresp, cmp_below_por, cmp_below_rst, cmp_below_warn, ring_osc_clk;
    wire         regulator_en, crystal_en, monitor_on, sram_retain, cpu_rst_b, cpu_stop, supply_warning_flag, irq;
    wire  [31:0] hrdata;
    wire  [15:0] boot_addr;
    wire  [23:0] pv = {boot_addr, regulator_en, crystal_en, monitor_on, sram_retain, cpu_rst_b, cpu_stop,
                       supply_warning_flag, irq};

    pfsms_supply_model pfsms_supply_model_i (.supply_lvl(supply_lvl), .cmp_below_por(cmp_below_por),
        .cmp_below_rst(cmp_below_rst), .cmp_below_warn(cmp_below_warn), .ring_osc_clk(ring_osc_clk));
    pfsms_top #(.XTAL_WARMUP_CYC(XW)) pfsms_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_below_por(cmp_below_por),
        .cmp_below_rst(cmp_below_rst), .cmp_below_warn(cmp_below_warn), .ring_osc_clk(ring_osc_clk),
        .ext_reset_pin_b(ext_reset_pin_b), .wdt_reset(wdt_reset), .io_wake_irq(io_wake_irq),
        .regulator_en(regulator_en), .crystal_en(crystal_en), .monitor_on(monitor_on),
        .sram_retain(sram_retain), .cpu_rst_b(cpu_rst_b), .cpu_stop(cpu_stop), .boot_addr(boot_addr),
        .supply_warning_flag(supply_warning_flag), .irq(irq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic summarize;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Notes an expectation and hands the observed value to the comparing process.
    task automatic note(input logic [31:0] exp, input logic [31:0] got, input logic [31:0] m);
        q.push_back({exp, m});
        obs <= got;
        pr  <= ~pr;
        @(posedge clk_sys);
    endtask

    // One single AHB transfer; read data are taken at the data-phase edge and compared under a mask.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        if (!w)
            note(d, hrdata, m);
    endtask

    // Bounded wait for one port bit; running out of cycles shows up as a mismatch.
    task automatic waitc(input int b, input logic v, input int lim, output int n);
        n = 0;
        while (pv[b] !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        note({31'h0, v}, {31'h0, pv[b]}, 32'h1);
    endtask

    // Compares each observation with the oldest note.
    always @(posedge clk_sys) begin
        if (pr !== pr_seen) begin
            pr_seen = pr;
            e = q.pop_front();
            samples_checked++;
            if ((obs & e[31:0]) !== (e[63:32] & e[31:0])) begin
                failures++;
                $display("wrong value at %0t: got %h want %h", $time, obs, e[63:32]);
            end
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Watchdog sized well above the longest sampling interval sequence.
    initial begin
        #800000;
        failures++;
        $display("wrong value at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        int n;
        int v;
        {rst_b, hsel, hwrite, wdt_reset, io_wake_irq, pr, pr_seen} = '0;
        {haddr, htrans, hwdata, obs} = '0;
        ext_reset_pin_b = 1'b1;
        supply_lvl = 2'h3;
        seed = 32'h71eace2d;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (30) @(posedge clk_sys);
        note(32'h0, {8'h0, pv}, 32'h88);
        supply_lvl <= 2'h0;
        waitc(3, 1'b1, XW + 100, n);
        note(32'he8, {8'h0, pv}, 32'hec);
        bus(1'b0, 8'h00, 32'h1, 32'hffffffff);
        bus(1'b0, 8'h04, 32'h0, 32'hffffffff);
        bus(1'b0, 8'h10, 32'h0, 32'hffffffff);
        seed = lfsr(seed);
        bus(1'b1, 8'h14, seed, 32'h0);
        bus(1'b0, 8'h14, 32'h0, 32'hffffffff);
        // Pin reset then watchdog reset, each held a random span.
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            ext_reset_pin_b <= (i != 0);
            wdt_reset <= (i == 1);
            repeat (6 + seed[2:0]) @(posedge clk_sys);
            note(32'he0, {8'h0, pv}, 32'he8);
            ext_reset_pin_b <= 1'b1;
            wdt_reset <= 1'b0;
            waitc(3, 1'b1, 19, n);
        end
        bus(1'b1, 8'h10, 32'h1, 32'h0);
        supply_lvl <= 2'h1;
        repeat (1500) @(posedge clk_sys);
        note(32'h0, {8'h0, pv}, 32'h2);
        waitc(1, 1'b1, 1000, n);
        note(32'hb, {8'h0, pv}, 32'hf);
        supply_lvl <= 2'h0;
        repeat (5) @(posedge clk_sys);
        bus(1'b1, 8'h0c, 32'hf, 32'h0);
        bus(1'b0, 8'h0c, 32'h0, 32'hf);
        bus(1'b1, 8'h10, 32'h0, 32'h0);
        bus(1'b1, 8'h00, 32'h9, 32'h0);
        waitc(2, 1'b1, 10, n);
        supply_lvl <= 2'h2;
        repeat (100) @(posedge clk_sys);
        note(32'h1c, {8'h0, pv}, 32'hfc);
        supply_lvl <= 2'h0;
        io_wake_irq <= 1'b1;
        waitc(2, 1'b0, XW + 50, n);
        io_wake_irq <= 1'b0;
        bus(1'b0, 8'h0c, 32'h8, 32'h8);
        seed = lfsr(seed);
        v = 2 + seed[1:0];
        bus(1'b1, 8'h0c, 32'hf, 32'h0);
        bus(1'b1, 8'h04, v, 32'h0);
        bus(1'b1, 8'h00, 32'h8, 32'h0);
        waitc(2, 1'b1, 10, n);
        note(32'h20, {8'h0, pv}, 32'h20);
        waitc(2, 1'b0, 9 * (v + 3) + XW + 50, n);
        bus(1'b0, 8'h0c, 32'ha, 32'ha);
        bus(1'b1, 8'h04, 32'h0, 32'h0);
        bus(1'b1, 8'h0c, 32'hf, 32'h0);
        bus(1'b1, 8'h00, 32'h8, 32'h0);
        waitc(2, 1'b1, 10, n);
        supply_lvl <= 2'h1;
        waitc(2, 1'b0, XW + 100, n);
        note(32'he2, {8'h0, pv}, 32'he3);
        supply_lvl <= 2'h0;
        repeat (5) @(posedge clk_sys);
        bus(1'b1, 8'h0c, 32'hf, 32'h0);
        // Supply fail with the shortest periodic interval, then recovery.
        bus(1'b1, 8'h00, 32'h2, 32'h0);
        supply_lvl <= 2'h2;
        waitc(3, 1'b0, 10, n);
        note(32'h10, {8'h0, pv}, 32'hd8);
        waitc(5, 1'b0, 100, n);
        waitc(5, 1'b1, 20000, n);
        waitc(5, 1'b0, 100, v);
        note(32'h1, {31'h0, v >= 12 && v <= 24}, 32'h1);
        waitc(5, 1'b1, 20000, n);
        n = (n + v) * 100 / 826;
        note(32'h1, {31'h0, n >= 2040 && n <= 2056}, 32'h1);
        supply_lvl <= 2'h0;
        waitc(3, 1'b1, 20000, n);
        note(32'h00800000, {8'h0, pv}, 32'h00ffff00);
        summarize();
    end
endmodule

bind pfsms_top pfsms_checker #(.XTAL_WARMUP_CYC(XTAL_WARMUP_CYC)) pfsms_checker_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp), .cmp_below_por(cmp_below_por),
    .cmp_below_rst(cmp_below_rst), .cmp_below_warn(cmp_below_warn), .ext_reset_pin_b(ext_reset_pin_b),
    .wdt_reset(wdt_reset), .regulator_en(regulator_en), .crystal_en(crystal_en), .monitor_on(monitor_on),
    .sram_retain(sram_retain), .cpu_rst_b(cpu_rst_b), .cpu_stop(cpu_stop), .boot_addr(boot_addr),
    .supply_warning_flag(supply_warning_flag));
